// file: hw/ntb_csr_pkg.sv
package ntb_csr_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses, one aligned 32-bit word each)
    // ------------------------------------------------------------------
    localparam int          ADDR_W                          = 12;
    localparam logic [11:0] OFF_DOWNSTREAM_WINDOW2_TRANSLATED_BASE = 12'h008;
    localparam logic [11:0] OFF_DOWNSTREAM_WINDOW2_SETUP           = 12'h00C;
    localparam logic [11:0] OFF_DOWNSTREAM_WINDOW3_TRANSLATED_BASE = 12'h010;
    localparam logic [11:0] OFF_DOWNSTREAM_WINDOW3_SETUP           = 12'h014;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_TRANSLATED_BASE = 32'h0000_0000;
    localparam logic [31:0] RST_SETUP           = 32'h0000_0000;

    // ------------------------------------------------------------------
    // field layouts
    // ------------------------------------------------------------------
    localparam logic [31:0] MASK_TRANSLATED_BASE = 32'hFFFF_F000; // bits 31:12
    localparam logic [31:0] MASK_SETUP_STORED    = 32'hFFFF_F00E; // 31:12, 3:1
    localparam logic [31:0] MASK_NONE            = 32'h0000_0000;
    localparam logic [31:0] MASK_WINDOW_FLOOR    = 32'h8000_0000; // bit 31 always decoded
    localparam int          SETUP_TYPE_SEL_BIT   = 0;
    localparam int          SETUP_ADDR_TYPE_LO   = 1;
    localparam int          SETUP_ADDR_TYPE_HI   = 2;
    localparam int          SETUP_PREFETCH_BIT   = 3;
    localparam int          SETUP_SIZE_LO        = 12;
    localparam int          SETUP_SIZE_HI        = 30;
    localparam int          SETUP_ENABLE_BIT     = 31;
    localparam logic [1:0]  ADDR_TYPE_32         = 2'h0;
    localparam logic [1:0]  ADDR_TYPE_64         = 2'h1;
    localparam int          NUM_WINDOWS          = 2;

    // stored registers of the block
    typedef struct packed {
        logic [31:0] tb2;
        logic [31:0] setup2;
        logic [31:0] tb3;
        logic [31:0] setup3;
    } csr_regs_s;

endpackage

// file: hw/window_cfg_if.sv
`timescale 1ns/1ps
interface window_cfg_if;
    logic [31:0] setup [ntb_csr_pkg::NUM_WINDOWS]; // setup word per window
    logic [31:0] tbase [ntb_csr_pkg::NUM_WINDOWS]; // translated base per window

    modport csr   (output setup, output tbase);
    modport xlate (input setup, input tbase);
endinterface // window_cfg_if

// file: hw/window_translate.sv
`timescale 1ns/1ps
module window_translate
(
    input  wire logic         clk_sys,       // system clock
    input  wire logic         rst,           // sync reset, active high
    window_cfg_if.xlate       cfg,           // window setup and translated bases
    input  wire logic [31:0]  win2_bar,      // window 2 base address (config space)
    input  wire logic [31:0]  win3_bar,      // window 3 base address (config space)
    input  wire logic         ds_valid,      // downstream memory request valid
    input  wire logic [31:0]  ds_addr,       // initiator address
    output logic              xl_valid,      // translated result valid
    output logic [31:0]       xl_addr,       // translated address
    output logic [1:0]        xl_hit,        // bit0 window 2, bit1 window 3
    output logic [31:0]       win2_bar_rw,   // writable bits of window 2 base
    output logic [31:0]       win3_bar_rw    // writable bits of window 3 base
);

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [1:0]  hit;
    } xl_state_s;

    xl_state_s   state;
    xl_state_s   next_state;
    logic [31:0] size_mask [ntb_csr_pkg::NUM_WINDOWS];
    logic [31:0] bar       [ntb_csr_pkg::NUM_WINDOWS];
    logic [1:0]  hit;

    assign bar[0] = win2_bar;
    assign bar[1] = win3_bar;

    // ------------------------------------------------------------------
    // per-window decode
    // ------------------------------------------------------------------
    // size bits gate the base register bits; bit 31 of the base always decodes
    for (genvar w = 0; w < ntb_csr_pkg::NUM_WINDOWS; w++)
    begin : g_win
        assign size_mask[w] = ntb_csr_pkg::MASK_WINDOW_FLOOR
                            | (cfg.setup[w] & ntb_csr_pkg::MASK_TRANSLATED_BASE
                               & ~ntb_csr_pkg::MASK_WINDOW_FLOOR);
        assign hit[w] = cfg.setup[w][ntb_csr_pkg::SETUP_ENABLE_BIT]
                      && (((ds_addr ^ bar[w]) & size_mask[w]) == 32'h0000_0000);
    end

    assign win2_bar_rw = size_mask[0] & {32{cfg.setup[0][ntb_csr_pkg::SETUP_ENABLE_BIT]}};
    assign win3_bar_rw = size_mask[1] & {32{cfg.setup[1][ntb_csr_pkg::SETUP_ENABLE_BIT]}};

    // translate: upper bits from translated base, offset kept; window 2 has priority
    always_comb
    begin
        next_state       = state;
        next_state.valid = ds_valid;
        next_state.hit   = ds_valid ? hit : 2'h0;
        next_state.addr  = ds_addr;
        if (hit[0])
            next_state.addr = (cfg.tbase[0] & size_mask[0])
                            | (ds_addr & ~size_mask[0]);
        else if (hit[1])
            next_state.addr = (cfg.tbase[1] & size_mask[1])
                            | (ds_addr & ~size_mask[1]);
    end

    // result register
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            state <= '0;
        else
            state <= next_state;
    end

    assign xl_valid = state.valid;
    assign xl_addr  = state.addr;
    assign xl_hit   = state.hit;

endmodule // window_translate

// file: hw/ntb_downstream_window_translation.sv
`timescale 1ns/1ps
// Overview of operation
// - registers reachable from primary and secondary ports
// - primary-read-only fields writable from secondary only
// - write-one clears bit; zero leaves it (no register here has such bits)
// - window 2 translated base bits 31:12
// - used base bits follow setup size mask
// - window 3 translated base bits 31:12
// - setup bit 0 reads zero: memory
// - setup address type and prefetchable bits
// - setup size bits make base bits writable
// - setup bit 31 enables window, reset off
module ntb_downstream_window_translation
(
    input  wire logic         clk_sys,       // system clock, 125 MHz
    input  wire logic         rst,           // sync reset, active high
    input  wire logic         pri_req,       // primary access request
    input  wire logic         pri_write,     // primary: 1 write, 0 read
    input  wire logic [11:0]  pri_addr,      // primary byte address
    input  wire logic [31:0]  pri_wdata,     // primary write data
    input  wire logic [3:0]   pri_be,        // primary byte enables
    output logic              pri_ack,       // primary completion pulse
    output logic [31:0]       pri_rdata,     // primary read data
    input  wire logic         sec_req,       // secondary access request
    input  wire logic         sec_write,     // secondary: 1 write, 0 read
    input  wire logic [11:0]  sec_addr,      // secondary byte address
    input  wire logic [31:0]  sec_wdata,     // secondary write data
    input  wire logic [3:0]   sec_be,        // secondary byte enables
    output logic              sec_ack,       // secondary completion pulse
    output logic [31:0]       sec_rdata,     // secondary read data
    input  wire logic [31:0]  win2_bar,      // window 2 base address
    input  wire logic [31:0]  win3_bar,      // window 3 base address
    input  wire logic         ds_valid,      // downstream memory request
    input  wire logic [31:0]  ds_addr,       // downstream initiator address
    output logic              xl_valid,      // translated address valid
    output logic [31:0]       xl_addr,       // translated address
    output logic [1:0]        xl_hit,        // window hit flags
    output logic [31:0]       win2_bar_rw,   // window 2 base writable bits
    output logic [31:0]       win3_bar_rw,   // window 3 base writable bits
    output logic              win2_addr64,   // window 2 is 64-bit type
    output logic              win2_prefetch, // window 2 prefetchable
    output logic              win3_addr64,   // window 3 is 64-bit type
    output logic              win3_prefetch  // window 3 prefetchable
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    // regs plus port answers
    typedef struct packed {
        ntb_csr_pkg::csr_regs_s regs;
        logic                   pri_ack;
        logic [31:0]            pri_rdata;
        logic                   sec_ack;
        logic [31:0]            sec_rdata;
    } csr_state_s;

    // present and next copy
    csr_state_s state;
    csr_state_s next_state;

    // carries setup and bases
    window_cfg_if cfg ();

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // byte enables to a bit mask
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // merge a write: plain bits take data, one-to-clear bits drop where data is 1
    function automatic logic [31:0] wr_field(input logic [31:0] old,
                                             input logic [31:0] wdata,
                                             input logic [3:0]  be,
                                             input logic [31:0] wmask,
                                             input logic [31:0] w1cmask);
        logic [31:0] wr;
        logic [31:0] clr;
        // be lanes gate all bits
        wr  = be_mask(be) & wmask;
        clr = be_mask(be) & w1cmask & wdata;
        return ((old & ~wr) | (wdata & wr)) & ~clr;
    endfunction

    // read decode shared by both ports; unmapped words read zero
    function automatic logic [31:0] rd_reg(input ntb_csr_pkg::csr_regs_s r,
                                           input logic [11:0] addr);
        logic [31:0] d;
        d = 32'h0000_0000;
        // bits 1:0 ignored
        unique case ({addr[11:2], 2'h0})
            ntb_csr_pkg::OFF_DOWNSTREAM_WINDOW2_TRANSLATED_BASE:
                d = r.tb2 & ntb_csr_pkg::MASK_TRANSLATED_BASE;
            ntb_csr_pkg::OFF_DOWNSTREAM_WINDOW2_SETUP:
                d = r.setup2 & ntb_csr_pkg::MASK_SETUP_STORED;
            ntb_csr_pkg::OFF_DOWNSTREAM_WINDOW3_TRANSLATED_BASE:
                d = r.tb3 & ntb_csr_pkg::MASK_TRANSLATED_BASE;
            ntb_csr_pkg::OFF_DOWNSTREAM_WINDOW3_SETUP:
                d = r.setup3 & ntb_csr_pkg::MASK_SETUP_STORED;
            default:
                d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    // apply one port's write; setup words only take the secondary side
    function automatic ntb_csr_pkg::csr_regs_s wr_regs(input ntb_csr_pkg::csr_regs_s r,
                                                       input logic [11:0] addr,
                                                       input logic [31:0] wdata,
                                                       input logic [3:0]  be,
                                                       input logic        from_sec);
        ntb_csr_pkg::csr_regs_s n;
        logic [31:0]            setup_mask;
        n          = r;
        setup_mask = from_sec ? ntb_csr_pkg::MASK_SETUP_STORED
                              : ntb_csr_pkg::MASK_NONE;
        unique case ({addr[11:2], 2'h0})
            ntb_csr_pkg::OFF_DOWNSTREAM_WINDOW2_TRANSLATED_BASE:
                n.tb2 = wr_field(r.tb2, wdata, be, ntb_csr_pkg::MASK_TRANSLATED_BASE,
                                 ntb_csr_pkg::MASK_NONE);
            ntb_csr_pkg::OFF_DOWNSTREAM_WINDOW2_SETUP:
                n.setup2 = wr_field(r.setup2, wdata, be, setup_mask,
                                    ntb_csr_pkg::MASK_NONE);
            ntb_csr_pkg::OFF_DOWNSTREAM_WINDOW3_TRANSLATED_BASE:
                n.tb3 = wr_field(r.tb3, wdata, be, ntb_csr_pkg::MASK_TRANSLATED_BASE,
                                 ntb_csr_pkg::MASK_NONE);
            ntb_csr_pkg::OFF_DOWNSTREAM_WINDOW3_SETUP:
                n.setup3 = wr_field(r.setup3, wdata, be, setup_mask,
                                    ntb_csr_pkg::MASK_NONE);
            default:
                n = r;
        endcase
        return n;
    endfunction

    // ------------------------------------------------------------------
    // register access from both ports
    // ------------------------------------------------------------------
    // primary applied first, so a same-cycle secondary write to one word wins
    always_comb
    begin
        next_state           = state;
        // ack even if refused
        next_state.pri_ack   = pri_req;
        next_state.sec_ack   = sec_req;
        next_state.pri_rdata = (pri_req && !pri_write) ? rd_reg(state.regs, pri_addr)
                                                       : 32'h0000_0000;
        next_state.sec_rdata = (sec_req && !sec_write) ? rd_reg(state.regs, sec_addr)
                                                       : 32'h0000_0000;
        // writes after reads
        if (pri_req && pri_write)
            next_state.regs = wr_regs(next_state.regs, pri_addr, pri_wdata, pri_be,
                                      1'b0);
        if (sec_req && sec_write)
            next_state.regs = wr_regs(next_state.regs, sec_addr, sec_wdata, sec_be,
                                      1'b1);
    end

    // state register; all fields return to their reset values
    // sticky bits: no own reset
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state             <= '0;
            state.regs.tb2    <= ntb_csr_pkg::RST_TRANSLATED_BASE;
            state.regs.setup2 <= ntb_csr_pkg::RST_SETUP;
            state.regs.tb3    <= ntb_csr_pkg::RST_TRANSLATED_BASE;
            state.regs.setup3 <= ntb_csr_pkg::RST_SETUP;
        end
        else
            state <= next_state;
    end

    // ------------------------------------------------------------------
    // outputs and translation
    // ------------------------------------------------------------------
    // registered port answers
    assign pri_ack   = state.pri_ack;
    assign pri_rdata = state.pri_rdata;
    assign sec_ack   = state.sec_ack;
    assign sec_rdata = state.sec_rdata;

    // window type decode; codes other than 32/64-bit read as 32-bit
    assign win2_addr64   = state.regs.setup2[ntb_csr_pkg::SETUP_ADDR_TYPE_HI:
                                             ntb_csr_pkg::SETUP_ADDR_TYPE_LO]
                           == ntb_csr_pkg::ADDR_TYPE_64;
    assign win3_addr64   = state.regs.setup3[ntb_csr_pkg::SETUP_ADDR_TYPE_HI:
                                             ntb_csr_pkg::SETUP_ADDR_TYPE_LO]
                           == ntb_csr_pkg::ADDR_TYPE_64;
    assign win2_prefetch = state.regs.setup2[ntb_csr_pkg::SETUP_PREFETCH_BIT];
    assign win3_prefetch = state.regs.setup3[ntb_csr_pkg::SETUP_PREFETCH_BIT];

    // window setup and bases travel to the translator
    assign cfg.setup[0] = state.regs.setup2;
    assign cfg.setup[1] = state.regs.setup3;
    assign cfg.tbase[0] = state.regs.tb2;
    assign cfg.tbase[1] = state.regs.tb3;

    // translator, one cycle
    window_translate u_xlate
    (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .cfg         (cfg.xlate),
        .win2_bar    (win2_bar),
        .win3_bar    (win3_bar),
        .ds_valid    (ds_valid),
        .ds_addr     (ds_addr),
        .xl_valid    (xl_valid),
        .xl_addr     (xl_addr),
        .xl_hit      (xl_hit),
        .win2_bar_rw (win2_bar_rw),
        .win3_bar_rw (win3_bar_rw)
    );

endmodule // ntb_downstream_window_translation

// file: tb/ntb_window_asserts.sv
`timescale 1ns/1ps
// ------------------------------
// port checker
// ------------------------------
module ntb_window_asserts
(
    input wire logic        clk_sys,     // clock
    input wire logic        rst,         // reset
    input wire logic        pri_req,     // pri request
    input wire logic        pri_write,   // pri write
    input wire logic [11:0] pri_addr,    // pri address
    input wire logic        pri_ack,     // pri ack
    input wire logic        sec_req,     // sec request
    input wire logic        sec_write,   // sec write
    input wire logic [11:0] sec_addr,    // sec address
    input wire logic [31:0] sec_wdata,   // sec data
    input wire logic [3:0]  sec_be,      // sec lanes
    input wire logic        sec_ack,     // sec ack
    input wire logic [31:0] win2_bar,    // base 2
    input wire logic [31:0] win3_bar,    // base 3
    input wire logic        ds_valid,    // ds request
    input wire logic [31:0] ds_addr,     // ds address
    input wire logic        xl_valid,    // result valid
    input wire logic [31:0] xl_addr,     // result address
    input wire logic [1:0]  xl_hit,      // hit flags
    input wire logic [31:0] win2_bar_rw, // mask 2
    input wire logic [31:0] win3_bar_rw, // mask 3
    input wire logic        win2_addr64  // type 2
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // hit terms, and the mask a full secondary setup write must leave
    logic        hit2;
    logic        hit3;
    logic [31:0] exp_mask;
    assign hit2 = win2_bar_rw[31] && ((ds_addr ^ win2_bar) & win2_bar_rw) == 32'h0;
    assign hit3 = win3_bar_rw[31] && ((ds_addr ^ win3_bar) & win3_bar_rw) == 32'h0;
    assign exp_mask = sec_wdata[31] ? {1'b1, sec_wdata[30:12], 12'h000} : 32'h0;

    sequence s_pri_setup_wr;
        pri_req && pri_write && pri_addr[11:2] == 10'h003 && !(sec_req && sec_write);
    endsequence
    sequence s_sec_setup_wr;
        sec_req && sec_write && sec_addr[11:2] == 10'h003 && sec_be == 4'hF;
    endsequence

    AST_PRI_ACK: assert property (pri_req |=> pri_ack)
        else $error("primary access not acknowledged");
    AST_SEC_ACK: assert property (sec_req |=> sec_ack)
        else $error("secondary access not acknowledged");
    AST_NO_STRAY_ACK: assert property (!pri_req && !sec_req |=> !pri_ack && !sec_ack)
        else $error("acknowledge without request");
    AST_PRI_SETUP_RO: assert property (s_pri_setup_wr |=> $stable(win2_bar_rw)
        && $stable(win2_addr64)) else $error("primary write moved setup");
    AST_SEC_SETUP_WR: assert property (s_sec_setup_wr |=> win2_bar_rw == $past(exp_mask)
        && win2_addr64 == ($past(sec_wdata[2:1]) == 2'h1)) else $error("setup write lost");
    AST_MASK_SHAPE: assert property (win3_bar_rw != 32'h0 |-> win3_bar_rw[31]
        && win3_bar_rw[11:0] == 12'h000) else $error("base mask malformed");
    AST_XL_FOLLOWS: assert property (ds_valid |=> xl_valid)
        else $error("translation result missing");
    AST_HIT2_OFFSET: assert property (ds_valid && hit2 |=> xl_hit[0]
        && ((xl_addr ^ $past(ds_addr)) & ~$past(win2_bar_rw)) == 32'h0)
        else $error("window 2 offset not kept");
    AST_HIT3: assert property (ds_valid && hit3 |=> xl_hit[1])
        else $error("window 3 hit missed");
    AST_MISS_PASS: assert property (ds_valid && !hit2 && !hit3 |=> xl_hit == 2'h0
        && xl_addr == $past(ds_addr)) else $error("miss altered address");
endmodule // ntb_window_asserts

bind ntb_downstream_window_translation ntb_window_asserts ntb_window_asserts_i (.clk_sys, .rst,
    .pri_req, .pri_write, .pri_addr, .pri_ack, .sec_req, .sec_write, .sec_addr, .sec_wdata,
    .sec_be, .sec_ack, .win2_bar, .win3_bar, .ds_valid, .ds_addr, .xl_valid, .xl_addr, .xl_hit,
    .win2_bar_rw, .win3_bar_rw, .win2_addr64);

// file: tb/ds_initiator.sv
`timescale 1ns/1ps
// ------------------------------
// downstream initiator model
// ------------------------------
module ds_initiator
(
    output logic        ds_valid, // request valid
    output logic [31:0] ds_addr   // initiator address
);
    logic [31:0] last = 32'h0;
    initial ds_valid = 1'b0;
    initial ds_addr = 32'h0;
    // one address per cycle; caller times it off the edge
    task automatic send(input logic [31:0] a);
        ds_valid = 1'b1;
        ds_addr = a;
        last = a;
    endtask
    // released bus shows the inverse so a stale address never looks live
    task automatic stop();
        ds_valid = 1'b0;
        ds_addr = ~last;
    endtask
endmodule // ds_initiator

// file: tb/tb_top.sv
`timescale 1ns/1ps
// ------------------------------
// bench
// ------------------------------
module tb_top;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        pri_req, pri_write, sec_req, sec_write, ds_valid, pri_ack, sec_ack, xl_valid;
    logic        win2_addr64, win2_prefetch, win3_addr64, win3_prefetch;
    logic [11:0] pri_addr, sec_addr;
    logic [3:0]  pri_be, sec_be;
    logic [1:0]  xl_hit;
    logic [31:0] pri_wdata, sec_wdata, win2_bar, win3_bar, ds_addr, pri_rdata, sec_rdata;
    logic [31:0] xl_addr, win2_bar_rw, win3_bar_rw;
    logic [31:0] m [4]; // shadow: base 2, setup 2, base 3, setup 3
    logic [31:0] lfsr = 32'h0000004C;
    logic [31:0] xa [6] = '{32'hA0001234, 32'hA000FFFC, 32'hA0010000, 32'hC00FFFFC,
                            32'hC0100000, 32'h9FFFFFFC};
    logic [31:0] qp[$], qs[$];
    logic [33:0] qx[$];
    int          n_mismatch = 0;
    int          n_compared = 0;

    always #4 clk_sys = ~clk_sys;

    ntb_downstream_window_translation ntb_downstream_window_translation_i (.clk_sys, .rst,
        .pri_req, .pri_write, .pri_addr, .pri_wdata, .pri_be, .pri_ack, .pri_rdata, .sec_req,
        .sec_write, .sec_addr, .sec_wdata, .sec_be, .sec_ack, .sec_rdata, .win2_bar, .win3_bar,
        .ds_valid, .ds_addr, .xl_valid, .xl_addr, .xl_hit, .win2_bar_rw, .win3_bar_rw,
        .win2_addr64, .win2_prefetch, .win3_addr64, .win3_prefetch);
    ds_initiator ds_initiator_i (.ds_valid, .ds_addr);

    // ------------------------------
    // helpers
    // ------------------------------
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    function automatic logic [31:0] msk(input logic [31:0] s);
        return s[31] ? {1'b1, s[30:12], 12'h000} : 32'h0;
    endfunction
    function automatic logic [31:0] rd_m(input logic [11:0] a);
        logic [2:0] i = a[4:2] - 3'h2;
        return (a[11:5] == 7'h0 && i < 3'h4) ? m[i] : 32'h0;
    endfunction
    task automatic chk_word(input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic chk_xl(input logic [33:0] e, input logic [33:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask
    // one access; the shadow moves only after the read expectation is noted
    task automatic acc(input bit s, w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        logic [31:0] k = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        logic [2:0]  i = a[4:2] - 3'h2;
        k &= a[2] ? (s ? ntb_csr_pkg::MASK_SETUP_STORED : 32'h0)
                  : ntb_csr_pkg::MASK_TRANSLATED_BASE;
        if (s)
            qs.push_back(w ? 32'h0 : rd_m(a));
        else
            qp.push_back(w ? 32'h0 : rd_m(a));
        if (s)
            {sec_req, sec_write, sec_addr, sec_wdata, sec_be} = {1'b1, w, a, d, be};
        else
            {pri_req, pri_write, pri_addr, pri_wdata, pri_be} = {1'b1, w, a, d, be};
        if (w && a[11:5] == 7'h0 && i < 3'h4)
            m[i] = (m[i] & ~k) | (d & k);
    endtask
    // released ports carry noise so a stale field cannot pass
    task automatic idle();
        {pri_req, sec_req} = 2'b00;
        {pri_wdata, sec_wdata} = {rnd(), rnd()};
        {pri_addr, sec_addr} = {pri_wdata[31:20], sec_wdata[31:20]};
        ds_initiator_i.stop();
        tick();
    endtask
    task automatic xs(input logic [31:0] a);
        logic [31:0] k2 = msk(m[1]);
        logic [31:0] k3 = msk(m[3]);
        logic        h2 = m[1][31] && ((a ^ win2_bar) & k2) == 32'h0;
        logic        h3 = m[3][31] && ((a ^ win3_bar) & k3) == 32'h0;
        if (h2)
            qx.push_back({h3, 1'b1, (m[0] & k2) | (a & ~k2)});
        else
            qx.push_back({h3, 1'b0, h3 ? (m[2] & k3) | (a & ~k3) : a});
        ds_initiator_i.send(a);
    endtask
    task automatic sweep();
        for (int a = 0; a < 32; a += 4)
        begin
            acc(1'b0, 1'b0, 12'(a), 32'h0, 4'hF);
            acc(1'b1, 1'b0, 12'(a), 32'h0, 4'hF);
            tick();
        end
        idle();
        chk_word(msk(m[1]), win2_bar_rw);
        chk_word(msk(m[3]), win3_bar_rw);
        chk_word({m[1][2:1] == 2'h1, m[1][3], m[3][2:1] == 2'h1, m[3][3]},
                 {win2_addr64, win2_prefetch, win3_addr64, win3_prefetch});
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // results judged mid-cycle, once the launching edge has settled
    always @(negedge clk_sys)
    begin
        if (pri_ack) chk_word(qp.pop_front(), pri_rdata);
        if (sec_ack) chk_word(qs.pop_front(), sec_rdata);
        if (xl_valid) chk_xl(qx.pop_front(), {xl_hit, xl_addr});
    end

    // hang guard
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        complete_run();
    end

    // ------------------------------
    // scenarios
    // ------------------------------
    initial
    begin
        logic [31:0] d;
        {pri_write, sec_write, pri_be, sec_be, win2_bar, win3_bar} = 74'h0;
        m = '{default: 32'h0};
        idle();
        repeat (9) @(posedge clk_sys);
        #1 rst = 1'b0;
        sweep();
        $display("test reset values done");
        for (int a = 0; a < 32; a += 4)
        begin
            acc(1'b0, 1'b1, 12'(a), 32'hFFFFFFFF, 4'hF);
            tick();
        end
        idle();
        sweep();
        $display("test primary writes done");
        for (int i = 0; i < 4; i++)
        begin
            d = rnd();
            d[3:1] = {i[1], 1'b0, i[0]};
            acc(1'b0, 1'b1, 12'h00C, ~d, 4'hF);
            acc(1'b1, 1'b1, 12'h00C, d, 4'hF);
            tick();
            acc(1'b1, 1'b1, 12'h014, ~d, 4'hF);
            acc(1'b0, 1'b1, 12'h010, rnd(), 4'(rnd()));
            tick();
        end
        for (int a = 0; a < 32; a += 4)
        begin
            acc(1'b1, 1'b1, 12'(a), rnd(), 4'(rnd()));
            tick();
        end
        idle();
        sweep();
        $display("test secondary writes done");
        {win2_bar, win3_bar} = {32'hA0000000, 32'hC0000000};
        acc(1'b1, 1'b1, 12'h00C, 32'hFFFF0000, 4'hF);
        acc(1'b0, 1'b1, 12'h008, 32'h12345678, 4'hF);
        tick();
        acc(1'b1, 1'b1, 12'h014, 32'hFFF00000, 4'hF);
        acc(1'b0, 1'b1, 12'h010, 32'h5AB00000, 4'hF);
        tick();
        idle();
        for (int r = 0; r < 2; r++)
        begin
            foreach (xa[j])
            begin
                xs(xa[j]);
                tick();
            end
            for (int j = 0; j < 8; j++)
            begin
                d = rnd();
                if (d[2]) d[31:16] = 16'hA000;
                xs(d);
                tick();
            end
            ds_initiator_i.stop();
            acc(1'b1, 1'b1, 12'h00C, 32'h7FFF0000, 4'hF);
            tick();
            idle();
        end
        $display("test translation done");
        acc(1'b0, 1'b0, 12'h010, 32'h0, 4'hF);
        acc(1'b1, 1'b1, 12'h010, 32'hABCDE000, 4'hC);
        tick();
        acc(1'b0, 1'b1, 12'h010, 32'h11111000, 4'hF);
        acc(1'b1, 1'b1, 12'h010, 32'h22222000, 4'h6);
        tick();
        idle();
        sweep();
        $display("test same cycle access done");
        rst = 1'b1;
        tick();
        tick();
        rst = 1'b0;
        m = '{default: 32'h0};
        sweep();
        $display("test second reset done");
        for (int i = 0; i < 20 && qp.size() + qs.size() + qx.size() > 0; i++) tick();
        if (qp.size() + qs.size() + qx.size() > 0) n_mismatch++;
        complete_run();
    end
endmodule // tb_top
